//--- shared/mmu_guard_pkg.sv
package mmu_guard_pkg;

   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int BUS_AW = 8;
   localparam int SFR_AW = 8;

   typedef enum logic [4:0]
   {
      MODE_BOOT = 5'h01,
      MODE_TEST = 5'h02,
      MODE_FW = 5'h04,
      MODE_SYS = 5'h08,
      MODE_USER = 5'h10
   } cpu_mode_e;

   // Access kinds double as the bit index into the segment rights.
   localparam logic [1:0] KIND_READ = 2'h0;
   localparam logic [1:0] KIND_WRITE = 2'h1;
   localparam logic [1:0] KIND_EXEC = 2'h2;
   localparam int SEG_END_BIT = 3;

   localparam logic [1:0] INT_IN_USER = 2'h0;
   localparam logic [1:0] INT_IN_SYS = 2'h1;
   localparam logic [1:0] INT_IN_FW = 2'h2;

   localparam logic [1:0] BANK_USER = 2'h0;
   localparam logic [1:0] BANK_SYS = 2'h1;
   localparam logic [1:0] BANK_SUPER = 2'h2;

   // Fixed physical partitioning, set at production.
   localparam logic [ADDR_W-1:0] ROM_FW_BASE = 24'h000000;
   localparam logic [ADDR_W-1:0] ROM_APP_BASE = 24'h010000;
   localparam logic [ADDR_W-1:0] ROM_END = 24'h060000;
   localparam logic [ADDR_W-1:0] RAM_FW_BASE = 24'h100000;
   localparam logic [ADDR_W-1:0] RAM_APP_BASE = 24'h100800;
   localparam logic [ADDR_W-1:0] RAM_END = 24'h102000;
   localparam logic [ADDR_W-1:0] EE_FW_BASE = 24'h200000;
   localparam logic [ADDR_W-1:0] EE_APP_BASE = 24'h204000;
   localparam logic [ADDR_W-1:0] EE_END = 24'h214000;

   localparam logic [ADDR_W-1:0] SYS_VEC_ADDR = 24'h7F0000;
   localparam logic [ADDR_W-1:0] FW_VEC_ADDR = 24'h7F8000;
   localparam logic [ADDR_W-1:0] USER_ENTRY_ADDR = 24'h800000;

   localparam logic [SFR_AW-1:0] SFR_FIXED_BASE = 8'h80;
   localparam logic [SFR_AW-1:0] SFR_LAST = 8'hF7;
   localparam logic [SFR_AW-1:0] SFR_BANK_LO = 8'hF0;
   localparam logic [SFR_AW-1:0] SFR_BANK_HI = 8'hF3;
   localparam logic [SFR_AW-1:0] SFR_KEY_ADDR = 8'h10;
   localparam logic [SFR_AW-1:0] SFR_RNG_ADDR = 8'h08;

   localparam logic [BUS_AW-1:0] OFS_MODE_CTL = 8'h00;
   localparam logic [BUS_AW-1:0] OFS_INT_MODE = 8'h04;
   localparam logic [BUS_AW-1:0] OFS_FW_SFR = 8'h08;
   localparam logic [BUS_AW-1:0] OFS_SEG_SEL = 8'h0C;
   localparam logic [BUS_AW-1:0] OFS_SEG_RIGHTS = 8'h10;
   localparam logic [BUS_AW-1:0] OFS_SEG_START = 8'h14;
   localparam logic [BUS_AW-1:0] OFS_SEG_END = 8'h18;
   localparam logic [BUS_AW-1:0] OFS_SEG_OFFS = 8'h1C;
   localparam logic [BUS_AW-1:0] OFS_SEG_SFR = 8'h20;
   localparam logic [BUS_AW-1:0] OFS_STATUS = 8'h24;

   localparam int MODE_CTL_SYS_BIT = 0;
   localparam logic [1:0] INT_MODE_RESET = 2'h1;
   localparam logic [3:0] SEG_RIGHTS_RESET = 4'h0;

endpackage

//--- logic/mmu_access_and_cpu_mode_guard.sv
`timescale 1ns/1ns
`default_nettype none
module mmu_access_and_cpu_mode_guard
#(
   parameter int SEG_COUNT = 64,
   parameter int SFR_GROUPS = 16
)
(
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic [mmu_guard_pkg::BUS_AW-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [mmu_guard_pkg::DATA_W-1:0] avs_writedata_in,
   output logic [mmu_guard_pkg::DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic acc_valid_in,
   input wire logic [1:0] acc_kind_in,
   input wire logic [mmu_guard_pkg::ADDR_W-1:0] acc_vaddr_in,
   input wire logic sfr_valid_in,
   input wire logic sfr_write_in,
   input wire logic [mmu_guard_pkg::SFR_AW-1:0] sfr_addr_in,
   input wire logic call_valid_in,
   input wire logic [mmu_guard_pkg::ADDR_W-1:0] call_target_in,
   input wire logic return_from_interrupt_instruction_in,
   input wire logic irq_take_in,
   input wire logic irq_active_in,
   input wire logic boot_done_in,
   input wire logic test_select_in,
   output logic mem_valid_out,
   output logic mem_write_out,
   output logic [mmu_guard_pkg::ADDR_W-1:0] mem_paddr_out,
   output logic sfr_grant_out,
   output logic [1:0] sfr_bank_out,
   output logic call_push_out,
   output logic exception_out,
   output logic reset_req_out,
   output logic [4:0] cpu_mode_out
);
   import mmu_guard_pkg::*;

   localparam int IW = $clog2(SEG_COUNT);

   cpu_mode_e mode_r, mode_nxt, saved_r, saved_nxt;
   logic special_r, special_nxt;
   logic reset_req_r;
   logic [1:0] int_mode_r;
   logic [SFR_GROUPS-1:0] fw_sfr_r;
   logic [SFR_GROUPS-1:0] cur_sfr_r;
   logic [IW-1:0] seg_sel_r;
   logic [3:0] cause_r;
   logic wait_r;
   logic [DATA_W-1:0] rdata_r, rd_mux;
   logic mem_valid_r, mem_write_r, sfr_grant_r, push_r, exc_r;
   logic [ADDR_W-1:0] paddr_r;
   logic [1:0] bank_r;

   logic [3:0] seg_rights_r [SEG_COUNT];
   logic [ADDR_W-1:0] seg_start_r [SEG_COUNT];
   logic [ADDR_W-1:0] seg_end_r [SEG_COUNT];
   logic [ADDR_W-1:0] seg_offs_r [SEG_COUNT];
   logic [SFR_GROUPS-1:0] seg_sfr_r [SEG_COUNT];

   // Mode decode.
   wire logic m_boot = mode_r == MODE_BOOT;
   wire logic m_test = mode_r == MODE_TEST;
   wire logic m_fw = mode_r == MODE_FW;
   wire logic m_sys = mode_r == MODE_SYS;
   wire logic m_user = mode_r == MODE_USER;
   wire logic m_super = m_boot | m_test | m_fw;

   // Register bus decode: one wait state, then the request is taken.
   wire logic bus_req = avs_read_in | avs_write_in;
   wire logic bus_wr = avs_write_in & ~wait_r;
   wire logic cfg_wr = bus_wr & m_sys;
   wire logic sel_mode = avs_address_in == OFS_MODE_CTL;
   wire logic sel_int = avs_address_in == OFS_INT_MODE;
   wire logic sel_fw = avs_address_in == OFS_FW_SFR;
   wire logic sel_seg = avs_address_in == OFS_SEG_SEL;
   wire logic sel_rights = avs_address_in == OFS_SEG_RIGHTS;
   wire logic sel_start = avs_address_in == OFS_SEG_START;
   wire logic sel_end = avs_address_in == OFS_SEG_END;
   wire logic sel_offs = avs_address_in == OFS_SEG_OFFS;
   wire logic sel_ssfr = avs_address_in == OFS_SEG_SFR;
   wire logic sel_stat = avs_address_in == OFS_STATUS;
   wire logic mode_clr = bus_wr & sel_mode & ~avs_writedata_in[MODE_CTL_SYS_BIT] & m_sys;

   // Segment lookup. Entries at and after an end marker are ignored.
   logic [SEG_COUNT:0] end_seen;
   logic [SEG_COUNT-1:0] seg_hit;
   assign end_seen[0] = 1'b0;
   genvar g;
   generate
      for (g = 0; g < SEG_COUNT; g++)
      begin : seg_cmp
         assign end_seen[g+1] = end_seen[g] | seg_rights_r[g][SEG_END_BIT];
         assign seg_hit[g] = ~end_seen[g+1] & (acc_vaddr_in >= seg_start_r[g])
            & (acc_vaddr_in <= seg_end_r[g]);
      end
   endgenerate

   logic [IW-1:0] hit_idx;
   always_comb
   begin
      hit_idx = '0;
      for (int k = SEG_COUNT - 1; k >= 0; k--)
      begin
         if (seg_hit[k])
            hit_idx = IW'(k);
      end
   end

   wire logic any_hit = |seg_hit;
   wire logic [3:0] hit_rights = seg_rights_r[hit_idx];
   wire logic right_ok = any_hit & hit_rights[acc_kind_in];
   // Identity outside user mode; relocation only in user mode.
   wire logic [ADDR_W-1:0] paddr = m_user ? ADDR_W'(acc_vaddr_in + seg_offs_r[hit_idx])
      : acc_vaddr_in;

   // Fixed partition check on the physical address.
   wire logic in_fw = (paddr >= ROM_FW_BASE && paddr < ROM_APP_BASE)
      | (paddr >= RAM_FW_BASE && paddr < RAM_APP_BASE)
      | (paddr >= EE_FW_BASE && paddr < EE_APP_BASE);
   wire logic in_app = (paddr >= ROM_APP_BASE && paddr < ROM_END)
      | (paddr >= RAM_APP_BASE && paddr < RAM_END)
      | (paddr >= EE_APP_BASE && paddr < EE_END);
   wire logic implemented = in_fw | in_app;
   wire logic part_ok = m_test ? 1'b1
      : (m_boot | m_fw) ? in_fw
      : in_app;
   wire logic seg_ok = ~m_user | right_ok;
   wire logic mem_viol = acc_valid_in & ((~implemented & ~m_test)
      | (implemented & ~part_ok) | ~seg_ok);

   // Peripheral register check.
   wire logic [3:0] grp = sfr_addr_in[6:3];
   wire logic sfr_cfg_area = sfr_addr_in < SFR_FIXED_BASE;
   wire logic sfr_impl = sfr_addr_in <= SFR_LAST;
   wire logic sfr_banked = sfr_addr_in >= SFR_BANK_LO && sfr_addr_in <= SFR_BANK_HI;
   wire logic [SFR_GROUPS-1:0] grp_rights = m_user ? cur_sfr_r
      : m_fw ? fw_sfr_r : '1;
   wire logic key_read = sfr_addr_in == SFR_KEY_ADDR && ~sfr_write_in;
   wire logic rng_write = sfr_addr_in == SFR_RNG_ADDR && sfr_write_in;
   wire logic cfg_ok = grp_rights[grp] & ~key_read & ~rng_write;
   wire logic fixed_ok = sfr_banked | m_sys | m_boot | m_test;
   wire logic sfr_viol = sfr_valid_in & (~sfr_impl
      | (sfr_cfg_area ? ~cfg_ok : ~fixed_ok));
   wire logic [1:0] bank_sel = m_user ? BANK_USER : m_sys ? BANK_SYS : BANK_SUPER;

   // Mode transition events.
   wire logic call_sys = call_valid_in & call_target_in == SYS_VEC_ADDR;
   wire logic call_fw = call_valid_in & call_target_in == FW_VEC_ADDR;
   wire logic call_user = call_valid_in & call_target_in == USER_ENTRY_ADDR & m_sys;
   wire logic system_entry_vector_bad = call_sys & ~m_user;
   wire logic return_from_interrupt_instruction_bad = return_from_interrupt_instruction_in & m_user
      & ~(int_mode_r == INT_IN_USER & irq_active_in);
   wire logic exc_now = mem_viol | sfr_viol | system_entry_vector_bad | return_from_interrupt_instruction_bad;

   always_comb
   begin
      mode_nxt = mode_r;
      saved_nxt = saved_r;
      special_nxt = special_r | exc_now;
      if (m_boot)
      begin
         if (boot_done_in)
         begin
            mode_nxt = test_select_in ? MODE_TEST : MODE_FW;
         end
      end
      else if (return_from_interrupt_instruction_in & ~return_from_interrupt_instruction_bad)
      begin
         mode_nxt = saved_r;
         special_nxt = exc_now;
      end
      else if (call_sys & m_user)
      begin
         saved_nxt = mode_r;
         mode_nxt = MODE_SYS;
      end
      else if (call_fw)
      begin
         saved_nxt = mode_r;
         mode_nxt = MODE_FW;
      end
      else if (call_user)
      begin
         mode_nxt = MODE_USER;
      end
      else if (irq_take_in)
      begin
         saved_nxt = mode_r;
         case (int_mode_r)
            INT_IN_USER: mode_nxt = MODE_USER;
            INT_IN_SYS: mode_nxt = MODE_SYS;
            default: mode_nxt = MODE_FW;
         endcase
      end
      else if (mode_clr)
      begin
         mode_nxt = MODE_USER;
      end
      // Boot is never a destination, so it is only ever left.
      if (mode_nxt == MODE_BOOT && ~m_boot)
      begin
         mode_nxt = mode_r;
      end
      if (saved_nxt == MODE_BOOT)
      begin
         saved_nxt = MODE_FW;
      end
   end

   always_comb
   begin
      case (1'b1)
         sel_mode: rd_mux = DATA_W'({special_r, mode_r, m_sys});
         sel_int: rd_mux = DATA_W'(int_mode_r);
         sel_fw: rd_mux = DATA_W'(fw_sfr_r);
         sel_seg: rd_mux = DATA_W'(seg_sel_r);
         sel_rights: rd_mux = DATA_W'(seg_rights_r[seg_sel_r]);
         sel_start: rd_mux = DATA_W'(seg_start_r[seg_sel_r]);
         sel_end: rd_mux = DATA_W'(seg_end_r[seg_sel_r]);
         sel_offs: rd_mux = DATA_W'(seg_offs_r[seg_sel_r]);
         sel_ssfr: rd_mux = DATA_W'(seg_sfr_r[seg_sel_r]);
         sel_stat: rd_mux = DATA_W'({reset_req_r, cause_r});
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         wait_r <= 1'b1;
         rdata_r <= '0;
      end
      else
      begin
         wait_r <= ~(bus_req & wait_r);
         if (bus_req & wait_r)
         begin
            rdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         mode_r <= MODE_BOOT;
         saved_r <= MODE_FW;
         special_r <= 1'b0;
         reset_req_r <= 1'b0;
         cause_r <= '0;
      end
      else
      begin
         mode_r <= mode_nxt;
         saved_r <= saved_nxt;
         special_r <= special_nxt;
         reset_req_r <= reset_req_r | (exc_now & special_r);
         if (exc_now)
         begin
            cause_r <= {return_from_interrupt_instruction_bad, system_entry_vector_bad, sfr_viol, mem_viol};
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         int_mode_r <= INT_MODE_RESET;
         fw_sfr_r <= '0;
         seg_sel_r <= '0;
      end
      else if (cfg_wr)
      begin
         if (sel_int)
            int_mode_r <= avs_writedata_in[1:0];
         if (sel_fw)
            fw_sfr_r <= avs_writedata_in[SFR_GROUPS-1:0];
         if (sel_seg)
            seg_sel_r <= avs_writedata_in[IW-1:0];
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         for (int k = 0; k < SEG_COUNT; k++)
         begin
            seg_rights_r[k] <= SEG_RIGHTS_RESET;
            seg_start_r[k] <= '0;
            seg_end_r[k] <= '0;
            seg_offs_r[k] <= '0;
            seg_sfr_r[k] <= '0;
         end
      end
      else if (cfg_wr)
      begin
         if (sel_rights)
            seg_rights_r[seg_sel_r] <= avs_writedata_in[3:0];
         if (sel_start)
            seg_start_r[seg_sel_r] <= avs_writedata_in[ADDR_W-1:0];
         if (sel_end)
            seg_end_r[seg_sel_r] <= avs_writedata_in[ADDR_W-1:0];
         if (sel_offs)
            seg_offs_r[seg_sel_r] <= avs_writedata_in[ADDR_W-1:0];
         if (sel_ssfr)
            seg_sfr_r[seg_sel_r] <= avs_writedata_in[SFR_GROUPS-1:0];
      end
   end

   // Register-group rights follow the segment of the last user fetch that had its execute right.
   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         cur_sfr_r <= '0;
      end
      else if (acc_valid_in & acc_kind_in == KIND_EXEC & m_user & right_ok)
      begin
         cur_sfr_r <= seg_sfr_r[hit_idx];
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         mem_valid_r <= 1'b0;
         mem_write_r <= 1'b0;
         paddr_r <= '0;
         sfr_grant_r <= 1'b0;
         bank_r <= BANK_SUPER;
         push_r <= 1'b0;
         exc_r <= 1'b0;
      end
      else
      begin
         mem_valid_r <= acc_valid_in & ~mem_viol;
         mem_write_r <= acc_valid_in & acc_kind_in == KIND_WRITE & ~mem_viol;
         paddr_r <= paddr;
         sfr_grant_r <= sfr_valid_in & ~sfr_viol;
         bank_r <= bank_sel;
         push_r <= (call_sys & m_user) | (call_fw & ~m_boot);
         exc_r <= exc_now;
      end
   end

   assign avs_readdata_out = rdata_r;
   assign avs_waitrequest_out = wait_r;
   assign mem_valid_out = mem_valid_r;
   assign mem_write_out = mem_write_r;
   assign mem_paddr_out = paddr_r;
   assign sfr_grant_out = sfr_grant_r;
   assign sfr_bank_out = bank_r;
   assign call_push_out = push_r;
   assign exception_out = exc_r;
   assign reset_req_out = reset_req_r;
   assign cpu_mode_out = mode_r;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);

   part_guard_a: assert property (acc_valid_in & m_sys & in_fw |=> exception_out & ~mem_valid_out)
      else $error("System mode reached a firmware memory part.");
   fw_part_a: assert property (acc_valid_in & m_fw & in_app |=> ~mem_valid_out)
      else $error("Firmware mode reached an application memory part.");
   seg_deny_a: assert property (acc_valid_in & m_user & acc_kind_in == KIND_WRITE & ~right_ok
      |=> ~mem_write_out & exception_out)
      else $error("User write passed without segment write right.");
   relocate_a: assert property (mem_valid_out & $past(m_user)
      |-> mem_paddr_out == ADDR_W'($past(acc_vaddr_in) + $past(seg_offs_r[hit_idx])))
      else $error("Relocated address is wrong.");
   second_exc_a: assert property (special_r & exc_now |=> reset_req_out)
      else $error("Second exception did not request reset.");
   system_entry_vector_only_user_a: assert property (call_sys & ~m_user |=> exception_out)
      else $error("System vector call outside user mode was not refused.");
   no_boot_back_a: assert property (~m_boot |=> cpu_mode_out != MODE_BOOT)
      else $error("Mode returned to boot.");
   user_entry_a: assert property (call_user & ~return_from_interrupt_instruction_in & ~call_fw |=> cpu_mode_out == MODE_USER
      & ~call_push_out)
      else $error("User entry call misbehaved.");
   key_read_a: assert property (sfr_valid_in & key_read |=> ~sfr_grant_out ##0 exception_out)
      else $error("Key register read was granted.");
   bus_wait_a: assert property (bus_req & wait_r |=> ~avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("Bus answer did not take exactly one wait state.");

   enter_user_c: cover property (m_sys ##1 m_user);
   seg_pass_c: cover property (acc_valid_in & m_user & right_ok);
   reset_req_c: cover property (exception_out ##[1:20] reset_req_out);
endmodule
`default_nettype wire

//--- verif/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model
(
   input wire logic clock_in,
   output logic acc_valid_out,
   output logic [1:0] acc_kind_out,
   output logic [23:0] acc_vaddr_out,
   output logic sfr_valid_out,
   output logic sfr_write_out,
   output logic [7:0] sfr_addr_out,
   output logic call_valid_out,
   output logic [23:0] call_target_out,
   output logic return_from_interrupt_instruction_out,
   output logic irq_take_out,
   output logic irq_active_out,
   output logic boot_done_out,
   output logic test_select_out
);
   initial
   begin
      {acc_valid_out, acc_kind_out, acc_vaddr_out, sfr_valid_out, sfr_write_out} = '0;
      {sfr_addr_out, call_valid_out, call_target_out, return_from_interrupt_instruction_out, irq_take_out} = '0;
      {irq_active_out, boot_done_out, test_select_out} = '0;
   end
   // Released address lines show the inverse of the last value, so stale data never matches.
   task automatic mem(input logic [1:0] k, input logic [23:0] a);
      @(posedge clock_in);
      acc_valid_out <= 1'h1;
      acc_kind_out <= k;
      acc_vaddr_out <= a;
      @(posedge clock_in);
      acc_valid_out <= 1'h0;
      acc_vaddr_out <= ~a;
   endtask
   task automatic peripheral_control_register(input logic w, input logic [7:0] a);
      @(posedge clock_in);
      sfr_valid_out <= 1'h1;
      sfr_write_out <= w;
      sfr_addr_out <= a;
      @(posedge clock_in);
      sfr_valid_out <= 1'h0;
      sfr_addr_out <= ~a;
   endtask
   task automatic call(input logic [23:0] t);
      @(posedge clock_in);
      call_valid_out <= 1'h1;
      call_target_out <= t;
      @(posedge clock_in);
      call_valid_out <= 1'h0;
      call_target_out <= ~t;
   endtask
   // One-cycle event: 0 leaves boot, 1 enters an interrupt, 2 returns.
   task automatic ev(input int e, input logic t);
      @(posedge clock_in);
      boot_done_out <= (e == 0);
      test_select_out <= t;
      irq_take_out <= (e == 1);
      return_from_interrupt_instruction_out <= (e == 2);
      @(posedge clock_in);
      {boot_done_out, irq_take_out, return_from_interrupt_instruction_out} <= 3'h0;
   endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import mmu_guard_pkg::*;
   logic clock_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [BUS_AW-1:0] avs_address_in;
   logic [DATA_W-1:0] avs_writedata_in, avs_readdata_out, rdat;
   logic acc_valid_in, sfr_valid_in, sfr_write_in, call_valid_in, return_from_interrupt_instruction_in, irq_take_in;
   logic irq_active_in, boot_done_in, test_select_in, mem_valid_out, mem_write_out;
   logic sfr_grant_out, call_push_out, exception_out, reset_req_out;
   logic [1:0] acc_kind_in, sfr_bank_out;
   logic [ADDR_W-1:0] acc_vaddr_in, call_target_in, mem_paddr_out;
   logic [SFR_AW-1:0] sfr_addr_in;
   logic [4:0] cpu_mode_out;
   int mismatches, comparisons;

   mmu_access_and_cpu_mode_guard uut
   (
      .clock_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
      .avs_readdata_out, .avs_waitrequest_out, .acc_valid_in, .acc_kind_in, .acc_vaddr_in,
      .sfr_valid_in, .sfr_write_in, .sfr_addr_in, .call_valid_in, .call_target_in, .return_from_interrupt_instruction_in,
      .irq_take_in, .irq_active_in, .boot_done_in, .test_select_in, .mem_valid_out,
      .mem_write_out, .mem_paddr_out, .sfr_grant_out, .sfr_bank_out, .call_push_out,
      .exception_out, .reset_req_out, .cpu_mode_out
   );
   core_model core
   (
      .clock_in, .acc_valid_out(acc_valid_in), .acc_kind_out(acc_kind_in),
      .acc_vaddr_out(acc_vaddr_in), .sfr_valid_out(sfr_valid_in), .sfr_write_out(sfr_write_in),
      .sfr_addr_out(sfr_addr_in), .call_valid_out(call_valid_in),
      .call_target_out(call_target_in), .return_from_interrupt_instruction_out(return_from_interrupt_instruction_in), .irq_take_out(irq_take_in),
      .irq_active_out(irq_active_in), .boot_done_out(boot_done_in),
      .test_select_out(test_select_in)
   );

   initial
   begin
      clock_in = 1'h0;
      forever #5 clock_in = ~clock_in;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Waitrequest and read data are taken at the rising edge, before the design updates them.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_in);
      avs_read_in <= !w;
      avs_write_in <= w;
      avs_address_in <= a;
      avs_writedata_in <= d;
      do
         @(posedge clock_in);
      while (avs_waitrequest_out !== 1'h0 && ++n < 50);
      if (n == 50)
         mismatches++;
      rdat = avs_readdata_out;
      avs_read_in <= 1'h0;
      avs_write_in <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk("readdata", e, rdat);
   endtask
   task automatic seg(input logic [31:0] i, r, s, e, o);
      bus(1'h1, OFS_SEG_SEL, i);
      bus(1'h1, OFS_SEG_RIGHTS, r);
      bus(1'h1, OFS_SEG_START, s);
      bus(1'h1, OFS_SEG_END, e);
      bus(1'h1, OFS_SEG_OFFS, o);
      bus(1'h1, OFS_SEG_SFR, 32'h0);
   endtask
   task automatic macc(input logic [1:0] k, input logic [23:0] a, input logic v,
                       input logic [23:0] p, input logic x);
      core.mem(k, a);
      #1;
      chk("mem_valid", 32'(v), 32'(mem_valid_out));
      chk("mem_write", 32'(v && k == KIND_WRITE), 32'(mem_write_out));
      if (v)
         chk("mem_paddr", 32'(p), 32'(mem_paddr_out));
      chk("exception", 32'(x), 32'(exception_out));
   endtask
   task automatic sacc(input logic w, input logic [7:0] a, input logic g, input logic x);
      core.peripheral_control_register(w, a);
      #1;
      chk("sfr_grant", 32'(g), 32'(sfr_grant_out));
      chk("exception", 32'(x), 32'(exception_out));
   endtask
   task automatic mchk(input cpu_mode_e m);
      chk("cpu_mode", 32'(m), 32'(cpu_mode_out));
   endtask
   task automatic vcall(input logic [23:0] t, input logic p, input cpu_mode_e m);
      core.call(t);
      #1;
      chk("call_push", 32'(p), 32'(call_push_out));
      mchk(m);
   endtask
   task automatic rst();
      @(posedge clock_in);
      srst_in <= 1'h1;
      repeat (3) @(posedge clock_in);
      srst_in <= 1'h0;
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      mismatches++;
      end_of_test();
   end

   initial
   begin
      mismatches = 0;
      comparisons = 0;
      srst_in = 1'h1;
      {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
      rst();
      #1;
      mchk(MODE_BOOT);
      chk("sfr_bank", 32'(BANK_SUPER), 32'(sfr_bank_out));
      macc(KIND_EXEC, ROM_FW_BASE + 24'h100, 1'h1, ROM_FW_BASE + 24'h100, 1'h0);
      macc(KIND_READ, RAM_APP_BASE, 1'h0, 24'h0, 1'h1);
      core.ev(0, 1'h1);
      #1;
      mchk(MODE_TEST);
      macc(KIND_READ, RAM_FW_BASE, 1'h1, RAM_FW_BASE, 1'h0);
      macc(KIND_WRITE, EE_APP_BASE, 1'h1, EE_APP_BASE, 1'h0);
      core.mem(KIND_READ, 24'h300000);
      #1;
      chk("exception", 32'h0, 32'(exception_out));
      core.ev(0, 1'h0);
      #1;
      mchk(MODE_TEST);
      rst();
      core.ev(0, 1'h0);
      #1;
      mchk(MODE_FW);
      macc(KIND_READ, RAM_APP_BASE, 1'h0, 24'h0, 1'h1);
      chk("reset_req", 32'h0, 32'(reset_req_out));
      vcall(SYS_VEC_ADDR, 1'h0, MODE_FW);
      chk("exception", 32'h1, 32'(exception_out));
      @(posedge clock_in);
      #1;
      chk("reset_req", 32'h1, 32'(reset_req_out));
      rst();
      core.ev(0, 1'h0);
      bus(1'h1, OFS_SEG_SEL, 32'h5);
      rd(OFS_SEG_SEL, 32'h0);
      sacc(1'h0, SFR_RNG_ADDR, 1'h0, 1'h1);
      core.ev(1, 1'h0);
      #1;
      mchk(MODE_SYS);
      sacc(1'h0, SFR_FIXED_BASE, 1'h1, 1'h0);
      sacc(1'h0, SFR_BANK_LO, 1'h1, 1'h0);
      chk("sfr_bank", 32'(BANK_SYS), 32'(sfr_bank_out));
      sacc(1'h0, SFR_KEY_ADDR, 1'h0, 1'h1);
      sacc(1'h1, SFR_KEY_ADDR, 1'h1, 1'h0);
      sacc(1'h0, SFR_LAST + 8'h1, 1'h0, 1'h1);
      macc(KIND_READ, ROM_APP_BASE, 1'h1, ROM_APP_BASE, 1'h0);
      macc(KIND_READ, RAM_FW_BASE, 1'h0, 24'h0, 1'h1);
      bus(1'h1, OFS_SEG_SEL, 32'd63);
      rd(OFS_SEG_SEL, 32'd63);
      // Segment 1 relocates into the firmware RAM, which partitioning must still refuse.
      seg(32'h0, 32'h5, 32'h800000, 32'h80FFFF, 32'h810000);
      seg(32'h1, 32'h3, 32'h900000, 32'h90FFFF, 32'h800000);
      seg(32'h2, 32'h8, 32'h0, 32'h0, 32'h0);
      bus(1'h1, OFS_SEG_SEL, 32'h0);
      rd(OFS_SEG_RIGHTS, 32'h5);
      rd(OFS_SEG_OFFS, 32'h810000);
      rd(8'hFC, 32'h0);
      bus(1'h0, OFS_MODE_CTL, 32'h0);
      chk("mode_ctl", 32'h11, rdat & 32'h3F);
      vcall(USER_ENTRY_ADDR, 1'h0, MODE_USER);
      macc(KIND_EXEC, 24'h800010, 1'h1, 24'h010010, 1'h0);
      macc(KIND_WRITE, 24'h800010, 1'h0, 24'h0, 1'h1);
      macc(KIND_READ, 24'h900000, 1'h0, 24'h0, 1'h1);
      macc(KIND_READ, 24'hA00000, 1'h0, 24'h0, 1'h1);
      bus(1'h1, OFS_MODE_CTL, 32'h1);
      #1;
      mchk(MODE_USER);
      sacc(1'h0, SFR_RNG_ADDR, 1'h0, 1'h1);
      core.ev(2, 1'h0);
      #1;
      chk("exception", 32'h1, 32'(exception_out));
      mchk(MODE_USER);
      vcall(SYS_VEC_ADDR, 1'h1, MODE_SYS);
      bus(1'h1, OFS_FW_SFR, 32'h2);
      bus(1'h1, OFS_INT_MODE, 32'h2);
      rd(OFS_INT_MODE, 32'h2);
      bus(1'h1, OFS_MODE_CTL, 32'h0);
      #1;
      mchk(MODE_USER);
      vcall(FW_VEC_ADDR, 1'h1, MODE_FW);
      sacc(1'h0, SFR_RNG_ADDR, 1'h1, 1'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
